// *** src/avs_defines.vh ***
// Command codes, frame fields and fixed values of the voltage bus slave
`ifndef AVS_DEFINES_VH
`define AVS_DEFINES_VH

// ------------------------------------------------------------
// Frame fields
// ------------------------------------------------------------
`define FRAME_BITS   6'h20
`define START_MSB    31
`define START_LSB    30
`define CMD_MSB      29
`define CMD_LSB      28
`define GROUP_BIT    27
`define TYPE_MSB     26
`define TYPE_LSB     23
`define SEL_MSB      22
`define SEL_LSB      19
`define DATA_MSB     18
`define DATA_LSB     3
`define CRC_MSB      2
`define START_CODE   2'h1

// ------------------------------------------------------------
// Commands, selectors and answers
// ------------------------------------------------------------
`define CMD_READ     2'h3
`define CMD_HOLD     2'h1
`define CMD_COMMIT   2'h0
`define CT_VOLTAGE   4'h0
`define CT_RATE      4'h1
`define CT_CURRENT   4'h2
`define CT_TEMP      4'h3
`define CT_VRESET    4'h4
`define CT_PMODE     4'h5
`define CT_STATUS    4'hE
`define CT_VERSION   4'hF
`define SEL_ALL      4'hF
`define ACK_OK       2'h0
`define ACK_BADCRC   2'h2
`define ACK_INVALID  2'h3

// ------------------------------------------------------------
// Status word and fixed data
// ------------------------------------------------------------
`define WARN_MASK    16'h70FE
`define PHASE_OC_BIT 4
`define PMODE_RST    16'h0000
`define VERSION_CODE 16'h0000
`define RESET_DATA   16'h0000
`define WRITE_FILL   16'hFFFF
`define SDATA_TAIL   5'h1F

`endif

// *** src/crc3_calc.v ***
// Three-bit frame checksum, polynomial x^3 + x + 1, over a parallel word
`timescale 1ns/1ps
`default_nettype none

module crc3_calc #(
  parameter WIDTH = 29
) (
  input  wire [WIDTH-1:0] data,
  output reg  [2:0]       crc
);

  integer k;
  reg     fb;

  // Serial division, first bit sent first
  always @* begin
    crc = 3'h0;
    fb  = 1'b0;
    for (k = WIDTH - 1; k >= 0; k = k - 1) begin
      fb  = data[k] ^ crc[2];
      crc = {crc[1], crc[0] ^ fb, fb};
    end
  end

endmodule // crc3_calc

`default_nettype wire

// *** src/frame_shifter.v ***
// Link sampling, 32-bit master frame capture and slave frame shift-out
`timescale 1ns/1ps
`default_nettype none
`include "avs_defines.vh"

module frame_shifter (
  input  wire        ref_clk,
  input  wire        rstn,
  input  wire        link_clk,
  input  wire        mdata_pin,
  input  wire        alert,
  input  wire [31:0] resp_word,
  input  wire        resp_valid,
  output reg  [31:0] frame_ff,
  output reg         frame_stb_ff,
  output reg         sdata_ff
);

  // ------------------------------------------------------------
  // Synchronisers and edge detect
  // ------------------------------------------------------------
  reg        clk_s1_ff;
  reg        clk_s2_ff;
  reg        clk_s3_ff;
  reg        md_s1_ff;
  reg        md_s2_ff;
  reg [5:0]  cnt_ff;
  reg [30:0] sh_ff;
  reg [31:0] nxt_resp_ff;
  reg        nxt_vld_ff;
  reg [31:0] cur_resp_ff;
  reg        cur_vld_ff;

  wire rise = clk_s2_ff & ~clk_s3_ff;
  wire fall = ~clk_s2_ff & clk_s3_ff;
  wire [5:0] out_idx = `FRAME_BITS - cnt_ff;

  always @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      clk_s1_ff <= 1'b0;
      clk_s2_ff <= 1'b0;
      clk_s3_ff <= 1'b0;
      md_s1_ff  <= 1'b1;
      md_s2_ff  <= 1'b1;
    end else begin
      clk_s1_ff <= link_clk;
      clk_s2_ff <= clk_s1_ff;
      clk_s3_ff <= clk_s2_ff;
      md_s1_ff  <= mdata_pin;
      md_s2_ff  <= md_s1_ff;
    end
  end

  // ------------------------------------------------------------
  // Frame counter, capture and answer shift
  // ------------------------------------------------------------
  always @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      cnt_ff       <= 6'h00;
      sh_ff        <= 31'h0000_0000;
      frame_ff     <= 32'h0000_0000;
      frame_stb_ff <= 1'b0;
      nxt_resp_ff  <= 32'hFFFF_FFFF;
      nxt_vld_ff   <= 1'b0;
      cur_resp_ff  <= 32'hFFFF_FFFF;
      cur_vld_ff   <= 1'b0;
      sdata_ff     <= 1'b1;
    end else begin
      frame_stb_ff <= 1'b0;
      if (frame_stb_ff) begin
        nxt_resp_ff <= resp_word;
        nxt_vld_ff  <= resp_valid;
      end
      if (rise && (cnt_ff != 6'h00 || !md_s2_ff)) begin
        sh_ff  <= {sh_ff[29:0], md_s2_ff};
        cnt_ff <= cnt_ff + 6'h01;
        // Answer of the previous frame starts with this one
        if (cnt_ff == 6'h00) begin
          cur_resp_ff <= nxt_resp_ff;
          cur_vld_ff  <= nxt_vld_ff;
        end
        if (cnt_ff == `FRAME_BITS - 6'h01) begin
          frame_ff     <= {sh_ff, md_s2_ff};
          frame_stb_ff <= 1'b1;
        end
      end else if (fall && cnt_ff != 6'h00) begin
        sdata_ff <= cur_vld_ff ? cur_resp_ff[out_idx[4:0]] : 1'b1;
        if (cnt_ff == `FRAME_BITS)
          cnt_ff <= 6'h00;
      end else if (cnt_ff == 6'h00) begin
        // Idle level doubles as the warning notification
        sdata_ff <= ~alert;
      end
    end
  end

endmodule // frame_shifter

`default_nettype wire

// *** src/avs_command_status_handler.v ***
// Command decode, warning status and answer build of the voltage bus slave
`timescale 1ns/1ps
`default_nettype none
`include "avs_defines.vh"

module avs_command_status_handler (
  input  wire        ref_clk,
  input  wire        rstn,
  input  wire        avs_clk,
  input  wire        avs_mdata,
  output wire        avs_sdata,
  input  wire        latch_off_fault,
  input  wire        conversion_en,
  input  wire        clear_faults,
  input  wire [1:0]  bus_owns_output,
  input  wire        reset_pin_low_flag,
  input  wire [1:0]  output_at_target,
  input  wire [31:0] boot_voltage,
  input  wire [31:0] init_target,
  input  wire [31:0] init_slew,
  input  wire [31:0] target_min,
  input  wire [31:0] target_max,
  input  wire [31:0] current_meas,
  input  wire [31:0] temp_meas,
  input  wire [31:0] warn_events,
  output wire [31:0] target_voltage,
  output wire [15:0] slew_rising,
  output wire [15:0] slew_falling,
  output wire [1:0]  settled
);

  localparam NCH = 2;

  // ------------------------------------------------------------
  // Frame fields
  // ------------------------------------------------------------
  wire [31:0] fr;
  wire        fr_stb;
  wire [2:0]  rx_crc;
  wire [2:0]  tx_crc;
  reg         init_done_ff;

  wire [1:0]  f_start = fr[`START_MSB:`START_LSB];
  wire [1:0]  f_cmd   = fr[`CMD_MSB:`CMD_LSB];
  wire        f_group = fr[`GROUP_BIT];
  wire [3:0]  f_type  = fr[`TYPE_MSB:`TYPE_LSB];
  wire [3:0]  f_sel   = fr[`SEL_MSB:`SEL_LSB];
  wire [15:0] f_data  = fr[`DATA_MSB:`DATA_LSB];

  wire crc_ok  = rx_crc == fr[`CRC_MSB:0];
  wire is_read = f_cmd == `CMD_READ;
  wire is_wr   = (f_cmd == `CMD_HOLD) | (f_cmd == `CMD_COMMIT);
  wire commit  = f_cmd == `CMD_COMMIT;
  wire sel_all = f_sel == `SEL_ALL;
  wire sel_one = f_sel[3:1] == 3'h0;
  wire ch      = f_sel[0];

  // Fault or disabled conversion drops the frame without answer
  wire live = fr_stb & ~latch_off_fault & conversion_en
            & (f_start == `START_CODE);

  // ------------------------------------------------------------
  // Per-channel state, flattened
  // ------------------------------------------------------------
  wire [31:0] tgt_all;
  wire [15:0] rise_all;
  wire [15:0] fall_all;
  wire [31:0] stat_all;
  wire [31:0] pmode_all;
  wire [1:0]  vdone_all;
  wire [1:0]  any_all;
  wire [1:0]  vnext_all;
  wire [1:0]  alert_all;

  function [15:0] pick16;
    input [31:0] v;
    input        c;
    pick16 = c ? v[31:16] : v[15:0];
  endfunction

  wire [15:0] cur_sel = pick16(current_meas, ch);

  // ------------------------------------------------------------
  // Command check and read mux
  // ------------------------------------------------------------
  reg        cmd_ok;
  reg [15:0] rd_data;

  always @* begin
    case (f_type)
      `CT_VOLTAGE, `CT_RATE, `CT_STATUS, `CT_PMODE:
        cmd_ok = (is_read & sel_one) | (is_wr & (sel_one | sel_all));
      `CT_CURRENT, `CT_TEMP:
        cmd_ok = is_read & sel_one;
      `CT_VRESET:
        cmd_ok = is_wr & (sel_one | sel_all) & (f_data == `RESET_DATA);
      `CT_VERSION:
        cmd_ok = is_read & sel_all;
      default:
        cmd_ok = 1'b0;
    endcase
    if (f_group)
      cmd_ok = 1'b0;
    case (f_type)
      `CT_VOLTAGE: rd_data = pick16(tgt_all, ch);
      `CT_RATE:    rd_data = ch ? {rise_all[15:8], fall_all[15:8]}
                                : {rise_all[7:0], fall_all[7:0]};
      `CT_CURRENT: rd_data = {1'b0, cur_sel[14:0]};
      `CT_TEMP:    rd_data = pick16(temp_meas, ch);
      `CT_PMODE:   rd_data = pick16(pmode_all, ch);
      `CT_STATUS:  rd_data = pick16(stat_all, ch);
      `CT_VERSION: rd_data = `VERSION_CODE;
      default:     rd_data = `WRITE_FILL;
    endcase
  end

  // ------------------------------------------------------------
  // Answer build
  // ------------------------------------------------------------
  wire [1:0] ack = !crc_ok ? `ACK_BADCRC :
                   cmd_ok  ? `ACK_OK : `ACK_INVALID;
  wire [15:0] tx_data = (ack == `ACK_OK && is_read) ? rd_data : `WRITE_FILL;

  // Summary shows the state this frame leaves behind
  // Broadcast summary merges both channels
  wire [4:0] summary = sel_all ?
    {&vnext_all, |any_all, &bus_owns_output, reset_pin_low_flag, 1'b0} :
    {vnext_all[ch], any_all[ch], bus_owns_output[ch],
     reset_pin_low_flag, 1'b0};

  wire [28:0] tx_body = {ack, 1'b0, summary, tx_data, `SDATA_TAIL};
  wire        accept  = live & crc_ok & cmd_ok & is_wr;

  crc3_calc #(
    .WIDTH (29)
  ) u_rx_crc (
    .data (fr[31:3]),
    .crc  (rx_crc)
  );

  crc3_calc #(
    .WIDTH (29)
  ) u_tx_crc (
    .data (tx_body),
    .crc  (tx_crc)
  );

  frame_shifter u_shift (
    .ref_clk      (ref_clk),
    .rstn         (rstn),
    .link_clk     (avs_clk),
    .mdata_pin    (avs_mdata),
    .alert        (|alert_all),
    .resp_word    ({tx_body, tx_crc}),
    .resp_valid   (live),
    .frame_ff     (fr),
    .frame_stb_ff (fr_stb),
    .sdata_ff     (avs_sdata)
  );

  // ------------------------------------------------------------
  // Start-up load of targets and slews
  // ------------------------------------------------------------
  always @(posedge ref_clk or negedge rstn) begin
    if (!rstn)
      init_done_ff <= 1'b0;
    else
      init_done_ff <= 1'b1;
  end

  // ------------------------------------------------------------
  // Channel registers
  // ------------------------------------------------------------
  genvar i;
  generate
    for (i = 0; i < NCH; i = i + 1) begin : g_ch
      localparam [0:0] IDX = i;
      reg [15:0] vtgt_ff;
      reg [15:0] vsh_ff;
      reg        vpend_ff;
      reg [7:0]  rise_ff;
      reg [7:0]  fall_ff;
      reg [15:0] rsh_ff;
      reg        rpend_ff;
      reg [15:0] pmode_ff;
      reg [15:0] warn_ff;
      reg        vdone_ff;
      reg        alert_ff;
      reg        pm_seen_ff;
      reg        bus_seen_ff;

      wire        hit = accept & (sel_all | (ch == IDX));
      wire [15:0] lo  = target_min[16*i +: 16];
      wire [15:0] hi  = target_max[16*i +: 16];
      wire [15:0] clamped = (f_data < lo) ? lo :
                            (f_data > hi) ? hi : f_data;
      wire v_wr = hit & (f_type == `CT_VOLTAGE);
      wire z_wr = hit & (f_type == `CT_VRESET);
      wire r_wr = hit & (f_type == `CT_RATE);
      wire p_wr = hit & (f_type == `CT_PMODE);
      wire s_wr = hit & (f_type == `CT_STATUS);
      wire [15:0] v_val  = z_wr ? boot_voltage[16*i +: 16] : clamped;
      wire        v_new  = hit & commit & (v_wr | z_wr | vpend_ff);
      wire [15:0] v_next = (v_wr | z_wr) ? v_val : vsh_ff;
      wire [15:0] r_next = r_wr ? f_data : rsh_ff;

      // Warning latch; a new event wins over a clear
      wire [15:0] evt    = warn_events[16*i +: 16] & `WARN_MASK;
      wire [15:0] clr    = s_wr ? (f_data & `WARN_MASK) : 16'h0000;
      wire        pm_any = pm_seen_ff | clear_faults;
      wire        bus_any = bus_seen_ff | clr[`PHASE_OC_BIT];
      wire        clr_ph = pm_any & bus_any;
      wire [15:0] clr_v  = {clr[15:5], clr_ph, clr[3:0]};
      wire [15:0] nxt_warn = (warn_ff & ~clr_v) | evt;
      wire        nxt_vdone = ~v_new & (vdone_ff | output_at_target[i]);

      always @(posedge ref_clk or negedge rstn) begin
        if (!rstn) begin
          vtgt_ff     <= 16'h0000;
          vsh_ff      <= 16'h0000;
          vpend_ff    <= 1'b0;
          rise_ff     <= 8'h00;
          fall_ff     <= 8'h00;
          rsh_ff      <= 16'h0000;
          rpend_ff    <= 1'b0;
          pmode_ff    <= `PMODE_RST;
          warn_ff     <= 16'h0000;
          vdone_ff    <= 1'b0;
          alert_ff    <= 1'b0;
          pm_seen_ff  <= 1'b0;
          bus_seen_ff <= 1'b0;
        end else if (!init_done_ff) begin
          vtgt_ff <= init_target[16*i +: 16];
          vsh_ff  <= init_target[16*i +: 16];
          rise_ff <= init_slew[16*i+8 +: 8];
          fall_ff <= init_slew[16*i +: 8];
        end else begin
          // Hold stages a voltage or rate value, commit applies everything staged for the channels it selects
          if ((v_wr | z_wr) && !commit) begin
            vsh_ff   <= v_val;
            vpend_ff <= 1'b1;
          end
          if (v_new) begin
            vtgt_ff  <= v_next;
            vpend_ff <= 1'b0;
          end
          if (r_wr && !commit) begin
            rsh_ff   <= f_data;
            rpend_ff <= 1'b1;
          end
          if (hit && commit && (r_wr || rpend_ff)) begin
            rise_ff  <= r_next[15:8];
            fall_ff  <= r_next[7:0];
            rpend_ff <= 1'b0;
          end
          if (p_wr)
            pmode_ff <= f_data;
          if (v_new)
            vdone_ff <= 1'b0;
          else if (output_at_target[i])
            vdone_ff <= 1'b1;
          warn_ff     <= nxt_warn;
          // Event and clear in one cycle: the event keeps the alert
          alert_ff    <= (|(evt & ~(warn_ff & ~clr_v))) | (alert_ff & ~s_wr);
          pm_seen_ff  <= nxt_warn[`PHASE_OC_BIT] & ~clr_ph & pm_any;
          bus_seen_ff <= nxt_warn[`PHASE_OC_BIT] & ~clr_ph & bus_any;
        end
      end

      assign tgt_all[16*i +: 16]   = vtgt_ff;
      assign rise_all[8*i +: 8]    = rise_ff;
      assign fall_all[8*i +: 8]    = fall_ff;
      assign stat_all[16*i +: 16]  = {vdone_ff, warn_ff[14:0]};
      assign pmode_all[16*i +: 16] = pmode_ff;
      assign vdone_all[i]          = vdone_ff;
      assign vnext_all[i]          = nxt_vdone;
      assign any_all[i]            = |nxt_warn;
      assign alert_all[i]          = alert_ff;
      assign slew_rising[8*i +: 8]  = rise_ff;
      assign slew_falling[8*i +: 8] = fall_ff;
    end
  endgenerate

  assign target_voltage = tgt_all;
  assign settled        = vdone_all;

endmodule // avs_command_status_handler

`default_nettype wire

// *** dv/avs_host_model.sv ***
// Bus host model: clocks one frame, shifts master bits, collects slave bits
`timescale 1ns/1ps
`default_nettype none
module avs_host_model (
  output logic      avs_clk,
  output logic      avs_mdata,
  input  wire logic avs_sdata
);
  initial begin
    avs_clk = 1'h0;
    avs_mdata = 1'h1;
  end
  // ------------------------------------------------------------
  // Frame checksum, MSB first, zero start
  // ------------------------------------------------------------
  function automatic logic [2:0] crc3(input logic [28:0] d);
    logic [2:0] c;
    c = 3'h0;
    for (int i = 28; i >= 0; i--)
      c = {c[1], c[0] ^ d[i] ^ c[2], d[i] ^ c[2]};
    return c;
  endfunction
  // ------------------------------------------------------------
  // One frame; clock stands low outside it, data idles high
  // ------------------------------------------------------------
  task automatic xfer(input logic [28:0] head, input logic bad, output logic [31:0] ans);
    logic [31:0] f;
    f = {head, crc3(head) ^ {2'h0, bad}};
    ans = 32'h0;
    #1.3;
    for (int i = 31; i >= 0; i--) begin
      avs_mdata = f[i];
      #24;
      avs_clk = 1'h1;
      if (i < 31)
        ans[i + 1] = avs_sdata;
      #24;
      avs_clk = 1'h0;
    end
    avs_mdata = 1'h1;
  endtask
endmodule // avs_host_model
`default_nettype wire

// *** dv/avs_handler_asserts.sv ***
// Port-level checker of the command and status block
`timescale 1ns/1ps
`default_nettype none
module avs_handler_asserts (
  input wire logic        ref_clk,
  input wire logic        rstn,
  input wire logic        latch_off_fault,
  input wire logic        conversion_en,
  input wire logic [1:0]  output_at_target,
  input wire logic [31:0] target_min,
  input wire logic [31:0] target_max,
  input wire logic [31:0] target_voltage,
  input wire logic [15:0] slew_rising,
  input wire logic [15:0] slew_falling,
  input wire logic [1:0]  settled
);
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!rstn);

  a_fault_freeze: assert property (latch_off_fault && $past(latch_off_fault)
    |-> $stable(target_voltage) && $stable(slew_rising) && $stable(slew_falling))
    else $error("state changed while latched off");
  a_disable_freeze: assert property (!conversion_en [*2]
    |=> $stable(target_voltage) && $stable(slew_rising))
    else $error("state changed while disabled");
  a_settled_cause: assert property ($rose(settled[0]) |-> $past(output_at_target[0]))
    else $error("settled A rose without output at target");
  a_settled_cause_b: assert property (!settled[1] ##1 settled[1] |-> $past(output_at_target[1]))
    else $error("settled B rose without output at target");
  a_settled_drop: assert property ($changed(target_voltage[15:0]) |-> !settled[0])
    else $error("settled A kept on new target");
  a_settled_drop_b: assert property ($changed(target_voltage[31:16]) |-> !settled[1])
    else $error("settled B kept on new target");
  a_clamp_chan_a: assert property ($changed(target_voltage[15:0])
    |-> target_voltage[15:0] >= target_min[15:0] && target_voltage[15:0] <= target_max[15:0])
    else $error("target A outside limits");
  a_clamp_chan_b: assert property ($changed(target_voltage[31:16])
    |-> target_voltage[31:16] >= target_min[31:16] && target_voltage[31:16] <= target_max[31:16])
    else $error("target B outside limits");
endmodule // avs_handler_asserts

bind avs_command_status_handler avs_handler_asserts u_asserts (
  .ref_clk          (ref_clk),
  .rstn             (rstn),
  .latch_off_fault  (latch_off_fault),
  .conversion_en    (conversion_en),
  .output_at_target (output_at_target),
  .target_min       (target_min),
  .target_max       (target_max),
  .target_voltage   (target_voltage),
  .slew_rising      (slew_rising),
  .slew_falling     (slew_falling),
  .settled          (settled)
);
`default_nettype wire

// *** dv/avs_command_status_handler_test.sv ***
// Self-checking bench of the command and status block
`timescale 1ns/1ps
`default_nettype none
module avs_command_status_handler_test;
  logic        ref_clk, rstn, latch_off_fault, conversion_en, clear_faults, reset_pin_low_flag;
  logic [1:0]  bus_owns_output, output_at_target;
  logic [31:0] boot_voltage, init_target, init_slew, target_min, target_max;
  logic [31:0] current_meas, temp_meas, warn_events, ans;
  wire         avs_clk, avs_mdata, avs_sdata;
  wire  [31:0] target_voltage;
  wire  [15:0] slew_rising, slew_falling;
  wire  [1:0]  settled;
  int          n_mismatch, total_checks;

  avs_command_status_handler DUT (
    .ref_clk(ref_clk), .rstn(rstn), .avs_clk(avs_clk), .avs_mdata(avs_mdata), .avs_sdata(avs_sdata),
    .latch_off_fault(latch_off_fault), .conversion_en(conversion_en), .clear_faults(clear_faults),
    .bus_owns_output(bus_owns_output), .reset_pin_low_flag(reset_pin_low_flag),
    .output_at_target(output_at_target), .boot_voltage(boot_voltage), .init_target(init_target),
    .init_slew(init_slew), .target_min(target_min), .target_max(target_max),
    .current_meas(current_meas), .temp_meas(temp_meas), .warn_events(warn_events),
    .target_voltage(target_voltage), .slew_rising(slew_rising), .slew_falling(slew_falling),
    .settled(settled)
  );
  avs_host_model host (.avs_clk(avs_clk), .avs_mdata(avs_mdata), .avs_sdata(avs_sdata));

  always #2 ref_clk = ~ref_clk;

  // ------------------------------------------------------------
  // Compare, frame and verdict tasks
  // ------------------------------------------------------------
  task automatic check(input string what, input logic [31:0] exp, input logic [31:0] got);
    total_checks++;
    if (got !== exp) begin
      n_mismatch++;
      $display("BAD %s expected %h seen %h", what, exp, got);
    end
  endtask
  task automatic tgt(input logic [31:0] e);
    check("target", e, target_voltage);
  endtask
  // Frame, then a version read that carries its answer back
  task automatic op(input logic [1:0] c, input logic [3:0] t, s, input logic [15:0] d,
                    input logic bad, input logic [1:0] ak, input logic [4:0] sm, input logic [15:0] r);
    logic [28:0] e;
    logic [31:0] x;
    e = {ak, 1'h0, sm, r, 5'h1F};
    host.xfer({2'h1, c, 1'h0, t, s, d}, bad, x);
    host.xfer({2'h1, 2'h3, 1'h0, 4'hF, 4'hF, 16'hFFFF}, 1'h0, ans);
    check("answer", {e, host.crc3(e)} & 32'hFFFF_FFFE, ans);
  endtask
  task automatic rd(input logic [3:0] t, s, input logic [4:0] sm, input logic [15:0] r);
    op(2'h3, t, s, 16'hFFFF, 1'h0, 2'h0, sm, r);
  endtask
  task automatic wr(input logic [1:0] c, input logic [3:0] t, s, input logic [15:0] d,
                    input logic [1:0] ak, input logic [4:0] sm);
    op(c, t, s, d, 1'h0, ak, sm, 16'hFFFF);
  endtask
  task automatic quiet;
    logic [31:0] x;
    host.xfer({2'h1, 2'h0, 1'h0, 4'h0, 4'h0, 16'h0258}, 1'h0, x);
    host.xfer({2'h1, 2'h3, 1'h0, 4'hF, 4'hF, 16'hFFFF}, 1'h0, ans);
    check("quiet", 32'hFFFF_FFFE, ans);
  endtask
  task automatic results;
    $display("mismatches %0d checks %0d", n_mismatch, total_checks);
    if (n_mismatch == 0 && total_checks > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask

  initial begin
    #250_000;
    n_mismatch++;
    results();
  end

  // ------------------------------------------------------------
  // Tests; summary A = {st, warn, 1, 1, 0}, B = {st, warn, 0, 1, 0}
  // ------------------------------------------------------------
  initial begin
    ref_clk = 1'h0;
    n_mismatch = 0;
    total_checks = 0;
    rstn <= 1'h0;
    latch_off_fault <= 1'h0;
    conversion_en <= 1'h1;
    clear_faults <= 1'h0;
    reset_pin_low_flag <= 1'h1;
    bus_owns_output <= 2'h1;
    output_at_target <= 2'h0;
    boot_voltage <= 32'h03E8_0370;
    init_target <= 32'h03B6_0384;
    init_slew <= 32'h0807_0605;
    target_min <= 32'h01F4_01F4;
    target_max <= 32'h05DC_05DC;
    current_meas <= 32'h1043_C123;
    temp_meas <= 32'hFF62_0358;
    warn_events <= 32'h0;
    repeat (8) @(posedge ref_clk);
    rstn <= 1'h1;
    repeat (3) @(posedge ref_clk);
    #1;
    tgt(32'h03B6_0384);
    check("rise", 32'h0806, {16'h0, slew_rising});
    check("settled", 32'h0, {30'h0, settled});
    rd(4'h0, 4'h0, 5'h06, 16'h0384);
    rd(4'h1, 4'h1, 5'h02, 16'h0807);
    wr(2'h0, 4'h0, 4'h0, 16'h0320, 2'h0, 5'h06);
    tgt(32'h03B6_0320);
    @(posedge ref_clk) output_at_target <= 2'h3;
    repeat (3) @(posedge ref_clk);
    #1;
    check("settled", 32'h3, {30'h0, settled});
    @(posedge ref_clk) output_at_target <= 2'h0;
    rd(4'h0, 4'h1, 5'h12, 16'h03B6);
    wr(2'h0, 4'h0, 4'h0, 16'h1388, 2'h0, 5'h06);
    tgt(32'h03B6_05DC);
    wr(2'h0, 4'h0, 4'h0, 16'h000A, 2'h0, 5'h06);
    tgt(32'h03B6_01F4);
    check("settled", 32'h2, {30'h0, settled});
    wr(2'h1, 4'h0, 4'h1, 16'h04B0, 2'h0, 5'h12);
    tgt(32'h03B6_01F4);
    wr(2'h0, 4'h1, 4'h1, 16'h0A02, 2'h0, 5'h02);
    tgt(32'h04B0_01F4);
    check("rise", 32'h0A06, {16'h0, slew_rising});
    check("fall", 32'h0205, {16'h0, slew_falling});
    wr(2'h0, 4'h4, 4'h0, 16'h0000, 2'h0, 5'h06);
    tgt(32'h04B0_0370);
    wr(2'h0, 4'h4, 4'h0, 16'h0001, 2'h3, 5'h06);
    tgt(32'h04B0_0370);
    wr(2'h0, 4'h0, 4'hF, 16'h02BC, 2'h0, 5'h02);
    tgt(32'h02BC_02BC);
    wr(2'h0, 4'h4, 4'hF, 16'h0000, 2'h0, 5'h02);
    tgt(32'h03E8_0370);
    rd(4'h2, 4'h0, 5'h06, 16'h4123);
    rd(4'h2, 4'h1, 5'h02, 16'h1043);
    rd(4'h3, 4'h1, 5'h02, 16'hFF62);
    rd(4'h3, 4'h0, 5'h06, 16'h0358);
    rd(4'h5, 4'h0, 5'h06, 16'h0000);
    wr(2'h0, 4'h5, 4'h0, 16'h1234, 2'h0, 5'h06);
    rd(4'h5, 4'h0, 5'h06, 16'h1234);
    wr(2'h0, 4'h2, 4'h0, 16'h0001, 2'h3, 5'h06);
    wr(2'h0, 4'h3, 4'h1, 16'h0001, 2'h3, 5'h02);
    op(2'h0, 4'h0, 4'h0, 16'h0320, 1'h1, 2'h2, 5'h06, 16'hFFFF);
    tgt(32'h03E8_0370);
    rd(4'hF, 4'hF, 5'h02, 16'h0000);
    @(posedge ref_clk) latch_off_fault <= 1'h1;
    quiet();
    @(posedge ref_clk) latch_off_fault <= 1'h0;
    conversion_en <= 1'h0;
    quiet();
    tgt(32'h03E8_0370);
    @(posedge ref_clk) conversion_en <= 1'h1;
    warn_events <= 32'h0000_FFFF;
    @(posedge ref_clk) warn_events <= 32'h0;
    repeat (4) @(posedge ref_clk);
    #1;
    check("alert", 32'h0, {31'h0, avs_sdata});
    rd(4'hE, 4'h0, 5'h0E, 16'h70FE);
    wr(2'h0, 4'hE, 4'h0, 16'h0000, 2'h0, 5'h0E);
    rd(4'hE, 4'h0, 5'h0E, 16'h70FE);
    wr(2'h0, 4'hE, 4'h0, 16'h70EE, 2'h0, 5'h0E);
    repeat (4) @(posedge ref_clk);
    #1;
    check("alert", 32'h1, {31'h0, avs_sdata});
    rd(4'hE, 4'h0, 5'h0E, 16'h0010);
    wr(2'h1, 4'hE, 4'h0, 16'h0010, 2'h0, 5'h0E);
    rd(4'hE, 4'h0, 5'h0E, 16'h0010);
    @(posedge ref_clk) warn_events <= 32'h1000_0000;
    clear_faults <= 1'h1;
    @(posedge ref_clk) warn_events <= 32'h0;
    clear_faults <= 1'h0;
    rd(4'hE, 4'h0, 5'h06, 16'h0000);
    rd(4'hE, 4'h1, 5'h0A, 16'h1000);
    wr(2'h0, 4'hE, 4'hF, 16'hFFFF, 2'h0, 5'h02);
    rd(4'hE, 4'h1, 5'h02, 16'h0000);
    @(posedge ref_clk) reset_pin_low_flag <= 1'h0;
    bus_owns_output <= 2'h3;
    rd(4'hF, 4'hF, 5'h04, 16'h0000);
    wr(2'h1, 4'h1, 4'h0, 16'h0A0B, 2'h0, 5'h04);
    check("rise", 32'h0A06, {16'h0, slew_rising});
    wr(2'h0, 4'h5, 4'h0, 16'h0000, 2'h0, 5'h04);
    check("rise", 32'h0A0A, {16'h0, slew_rising});
    check("fall", 32'h020B, {16'h0, slew_falling});
    rd(4'h1, 4'h0, 5'h04, 16'h0A0B);
    results();
  end
endmodule // avs_command_status_handler_test
`default_nettype wire
